// ===== rtl/fbr_burst_read.sv
`timescale 1ns/1ps
`include "fbr_regs.svh"
module fbr_burst_read #(
	parameter int AW = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Host burst pins
	input wire logic burstClk,
	input wire logic burstEnable,
	input wire logic [AW-1:0] burstAddr,
	output fbr_pkg::fbr_host_out_t hostOut,
	// Flash array read port
	output logic arrayReq,
	output logic [AW-1:0] arrayAddr,
	input wire logic arrayValid,
	input wire logic [15:0] arrayData
);
	// Wrap masks and the row check both reach four address bits
	if (AW < 5) begin : g_aw_check
		$error("fbr_burst_read needs AW of at least 5");
	end

	typedef struct packed {
		logic [15:0] cfg;
		logic phaseWrite;
		logic [7:0] phaseAddr;
		logic [31:0] rdata;
		logic [1:0] clkSync;
		logic clkPrev;
		logic [1:0] enSync;
		logic [AW-1:0] addrSync1;
		logic [AW-1:0] addrSync2;
		fbr_pkg::fbr_state_t st;
		logic [AW-1:0] addr;
		logic [1:0] startLow;
		logic [2:0] lenCode;
		logic cont;
		logic linear;
		logic [4:0] remain;
		logic [4:0] fetched;
		logic [4:0] target;
		logic [AW-1:0] fetchAddr;
		logic fetchEnd;
		logic pending;
		logic [15:0] hold;
		logic holdValid;
		logic [15:0] pref;
		logic prefValid;
		logic crossed;
		logic [2:0] delayCnt;
		logic [15:0] delivered;
		logic req;
		logic [AW-1:0] reqAddr;
		fbr_pkg::fbr_host_out_t out;
	} fbr_regs_t;

	fbr_regs_t s_reg;
	fbr_regs_t s_next;
	logic [AW-1:0] fetchNext;
	logic [AW-1:0] deliverNext;

	fbr_next_addr #(.AW(AW)) u_fetch_next (
		.addr(s_reg.fetchAddr),
		.lenCode(s_reg.lenCode),
		.linear(s_reg.linear),
		.nextAddr(fetchNext)
	);
	fbr_next_addr #(.AW(AW)) u_deliver_next (
		.addr(s_reg.addr),
		.lenCode(s_reg.lenCode),
		.linear(s_reg.linear),
		.nextAddr(deliverNext)
	);

	logic activeEdge;
	logic fetchOk;
	logic [2:0] lat;
	logic [2:0] gap;
	logic [2:0] delay;
	logic [2:0] code;

	always_comb begin
		s_next = s_reg;
		// Registers fit in one cycle, so the slave never stretches a transfer
		if (s_reg.phaseWrite && s_reg.phaseAddr == `FBR_CFG_OFFSET) begin
			s_next.cfg = hwdata[15:0];
		end
		s_next.phaseWrite = 1'b0;
		if (hsel && hready && htrans[1]) begin
			s_next.phaseWrite = hwrite;
			s_next.phaseAddr = haddr[7:0];
			case (haddr[7:0])
				`FBR_CFG_OFFSET: s_next.rdata = {16'h0000, s_reg.cfg};
				`FBR_STATUS_OFFSET: s_next.rdata = {14'h0000, s_reg.st == fbr_pkg::ST_STREAM,
					s_reg.out.waitOut, s_reg.delivered};
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end

		// Burst clock and pins cross in through two flops
		s_next.clkSync = {s_reg.clkSync[0], burstClk};
		s_next.clkPrev = s_reg.clkSync[1];
		s_next.enSync = {s_reg.enSync[0], burstEnable};
		s_next.addrSync1 = burstAddr;
		s_next.addrSync2 = s_reg.addrSync1;
		if (s_reg.cfg[`FBR_EDGE_BIT]) begin
			activeEdge = s_reg.clkSync[1] & ~s_reg.clkPrev;
		end else begin
			activeEdge = ~s_reg.clkSync[1] & s_reg.clkPrev;
		end

		lat = s_reg.cfg[`FBR_LAT_MSB:`FBR_LAT_LSB];
		gap = {1'b0, 2'h3 - s_reg.startLow};
		delay = (lat > gap + 3'h1) ? lat - gap - 3'h1 : 3'h1;
		code = s_reg.cfg[`FBR_LEN_MSB:`FBR_LEN_LSB];

		// Fixed bursts keep no word ahead; continuous keeps one prefetched
		if (s_reg.cont) begin
			fetchOk = !s_reg.prefValid && !s_reg.fetchEnd;
		end else begin
			fetchOk = !s_reg.holdValid && s_reg.fetched != s_reg.target;
		end

		s_next.req = 1'b0;
		if (arrayValid && s_reg.pending) begin
			s_next.pending = 1'b0;
			if (s_reg.st == fbr_pkg::ST_STREAM) begin
				if (!s_reg.holdValid) begin
					s_next.hold = arrayData;
					s_next.holdValid = 1'b1;
				end else begin
					s_next.pref = arrayData;
					s_next.prefValid = 1'b1;
				end
				s_next.fetched = s_reg.fetched + 5'h01;
				s_next.fetchAddr = fetchNext;
				if (s_reg.cont && &s_reg.fetchAddr) begin
					s_next.fetchEnd = 1'b1;
				end
			end
		end else if (s_reg.st == fbr_pkg::ST_STREAM && !s_reg.pending && fetchOk) begin
			s_next.req = 1'b1;
			s_next.reqAddr = s_reg.fetchAddr;
			s_next.pending = 1'b1;
		end

		case (s_reg.st)
			fbr_pkg::ST_IDLE: begin
				if (activeEdge && s_reg.enSync[1] && !s_reg.pending) begin
					s_next.st = fbr_pkg::ST_STREAM;
					s_next.addr = s_reg.addrSync2;
					s_next.fetchAddr = s_reg.addrSync2;
					s_next.startLow = s_reg.addrSync2[1:0];
					s_next.cont = code == `FBR_LEN_CONT;
					s_next.lenCode = code;
					s_next.linear = s_reg.cfg[`FBR_NOWRAP_BIT] || code == `FBR_LEN_CONT;
					case (code)
						`FBR_LEN_8: s_next.target = 5'h08;
						`FBR_LEN_16: s_next.target = 5'h10;
						default: s_next.target = 5'h04;
					endcase
					s_next.remain = s_next.target;
					s_next.fetched = 5'h00;
					s_next.fetchEnd = 1'b0;
					s_next.holdValid = 1'b0;
					s_next.prefValid = 1'b0;
					s_next.crossed = 1'b0;
					s_next.delayCnt = 3'h0;
					s_next.out.waitOut = 1'b1;
				end
			end
			fbr_pkg::ST_STREAM: begin
				if (!s_reg.enSync[1]) begin
					s_next.st = fbr_pkg::ST_IDLE;
					s_next.out.waitOut = 1'b0;
					s_next.holdValid = 1'b0;
					s_next.prefValid = 1'b0;
				end else if (activeEdge) begin
					if (s_reg.delayCnt != 3'h0) begin
						s_next.delayCnt = s_reg.delayCnt - 3'h1;
						s_next.out.waitOut = 1'b1;
					end else if (s_reg.holdValid) begin
						s_next.out.data = s_reg.hold;
						s_next.out.waitOut = 1'b0;
						// A word landing in this same cycle moves up instead of being dropped
						s_next.hold = s_next.pref;
						s_next.holdValid = s_next.prefValid;
						s_next.prefValid = 1'b0;
						s_next.addr = deliverNext;
						s_next.remain = s_reg.remain - 5'h01;
						s_next.delivered = s_reg.delivered + 16'h0001;
						if (s_reg.linear && !s_reg.crossed && deliverNext[3:0] == 4'h0) begin
							s_next.crossed = 1'b1;
							if (s_reg.startLow != 2'h0) begin
								s_next.delayCnt = delay;
							end
						end
						if ((!s_reg.cont && s_reg.remain == 5'h01) || (s_reg.cont && &s_reg.addr)) begin
							s_next.st = fbr_pkg::ST_IDLE;
							s_next.holdValid = 1'b0;
						end
					end else begin
						s_next.out.waitOut = 1'b1;
					end
				end
			end
			default: s_next.st = fbr_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
			s_reg.cfg <= `FBR_CFG_RESET;
			s_reg.st <= fbr_pkg::ST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_reg.rdata;
	assign hostOut = s_reg.out;
	assign arrayReq = s_reg.req;
	assign arrayAddr = s_reg.reqAddr;
endmodule

// ===== rtl/fbr_regs.svh
`ifndef FBR_REGS_SVH
`define FBR_REGS_SVH
// What this block does
// - Edge bit picks rising or falling burst edge
// - Wrap mode stays inside aligned burst block
// - No-wrap mode runs linearly across block boundary
// - Wait holds host off until data valid
// - Fixed no-wrap bursts fetch only needed words
// - Continuous burst is linear and prefetches ahead
// - Length field sets 4, 8, 16, continuous
// - Continuous burst never wraps
// - Continuous burst runs to address space end
// - Misaligned start delays once at row crossing
// - Start at group end delays latency minus one
`define FBR_CFG_OFFSET 8'h00
`define FBR_STATUS_OFFSET 8'h04
`define FBR_CFG_RESET 16'h1807
`define FBR_LEN_MSB 2
`define FBR_LEN_LSB 0
`define FBR_NOWRAP_BIT 3
`define FBR_EDGE_BIT 6
`define FBR_LAT_MSB 13
`define FBR_LAT_LSB 11
`define FBR_LEN_4 3'h1
`define FBR_LEN_8 3'h2
`define FBR_LEN_16 3'h3
`define FBR_LEN_CONT 3'h7
`endif

// ===== rtl/fbr_pkg.sv
package fbr_pkg;
	typedef enum logic [0:0] {ST_IDLE, ST_STREAM} fbr_state_t;
	typedef struct packed {
		logic waitOut;
		logic [15:0] data;
	} fbr_host_out_t;
endpackage

// ===== rtl/fbr_next_addr.sv
`timescale 1ns/1ps
`include "fbr_regs.svh"
module fbr_next_addr #(
	parameter int AW = 16
) (
	// Current word and mode
	input wire logic [AW-1:0] addr,
	input wire logic [2:0] lenCode,
	input wire logic linear,
	// Following word
	output logic [AW-1:0] nextAddr
);
	logic [AW-1:0] inc;
	logic [AW-1:0] mask;
	always_comb begin
		inc = addr + {{(AW-1){1'b0}}, 1'b1};
		case (lenCode)
			`FBR_LEN_8: mask = {{(AW-3){1'b0}}, 3'h7};
			`FBR_LEN_16: mask = {{(AW-4){1'b0}}, 4'hf};
			default: mask = {{(AW-2){1'b0}}, 2'h3};
		endcase
		if (linear) begin
			nextAddr = inc;
		end else begin
			nextAddr = (addr & ~mask) | (inc & mask);
		end
	end
endmodule

// ===== tb/fbr_burst_read_chk.sv
`timescale 1ns/1ps
module fbr_chk #(
	parameter int AW = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Watched ports
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic burstClk,
	input wire fbr_pkg::fbr_host_out_t hostOut,
	input wire logic arrayReq,
	input wire logic [AW-1:0] arrayAddr,
	input wire logic arrayValid
);
	logic pend_reg;
	logic clkOld_reg;
	logic [3:0] age_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Age counts clocks since the raw burst clock last moved; synchronisers add a few
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg <= 1'h0;
			clkOld_reg <= 1'h0;
			age_reg <= 4'h0;
		end else begin
			pend_reg <= arrayReq | (pend_reg & ~arrayValid);
			clkOld_reg <= burstClk;
			age_reg <= (burstClk != clkOld_reg) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
		end
	end
	AST_ONE_PENDING: assert property (arrayReq |-> !pend_reg)
		else $error("array request while one outstanding");
	AST_REQ_PULSE: assert property (arrayReq |=> !arrayReq)
		else $error("array request longer than one cycle");
	AST_ADDR_HOLD: assert property ($changed(arrayAddr) |-> arrayReq)
		else $error("array address moved without request");
	AST_DATA_WAIT: assert property ($changed(hostOut.data) |-> !hostOut.waitOut)
		else $error("data word moved while wait high");
	AST_DATA_EDGE: assert property ($changed(hostOut.data) |-> age_reg <= 4'h6)
		else $error("data word moved away from burst edge");
	AST_WAIT_EDGE: assert property ($rose(hostOut.waitOut) |-> age_reg <= 4'h6)
		else $error("wait rose away from burst edge");
	AST_HRESP: assert property (!hresp)
		else $error("error response");
	AST_HREADY: assert property (hreadyout)
		else $error("bus stalled");
endmodule
bind fbr_burst_read fbr_chk #(.AW(AW)) u_fbr_chk (.clock(clock), .arst_n(arst_n), .hreadyout(hreadyout),
	.hresp(hresp), .burstClk(burstClk), .hostOut(hostOut), .arrayReq(arrayReq), .arrayAddr(arrayAddr),
	.arrayValid(arrayValid));

// ===== tb/fbr_array_model.sv
`timescale 1ns/1ps
module fbr_array_model (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Array port
	input wire logic arrayReq,
	input wire logic [15:0] arrayAddr,
	input wire logic slow,
	output logic arrayValid,
	output logic [15:0] arrayData
);
	logic [3:0] cnt_reg;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 4'h0;
		end else if (arrayReq) begin
			cnt_reg <= slow ? 4'h9 : 4'h2;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
	assign arrayValid = cnt_reg == 4'h1;
	// Outside the valid cycle the bus shows junk, never the word
	assign arrayData = arrayValid ? arrayAddr ^ 16'ha5c3 : ~arrayAddr;
endmodule

// ===== tb/fbr_burst_read_tb.sv
`timescale 1ns/1ps
`include "fbr_regs.svh"
`define CHK(nm, expv, gotv) begin nCompared++; if ((gotv) !== (expv)) begin badCount++; $display("[FAIL] %s exp %h got %h", nm, expv, gotv); end end
module fbr_burst_read_tb;
	localparam int HALF = 10;
	logic clock = 1'h0, arst_n = 1'h0, hsel = 1'h1, hwrite = 1'h0, burstClk = 1'h1, burstEnable = 1'h0, slow = 1'h0;
	logic edgeSel = 1'h0, prevWait = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [15:0] burstAddr = 16'h0, prevData = 16'h0, arrayData, arrayAddr, gotExp;
	logic hreadyout, hresp, arrayReq, arrayValid;
	fbr_pkg::fbr_host_out_t hostOut;
	logic [15:0] expQ[$];
	int badCount = 0, nCompared = 0, waitCycles = 0, nWords = 0, i;
	fbr_burst_read u_fbr_burst_read (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .burstClk(burstClk), .burstEnable(burstEnable), .burstAddr(burstAddr), .hostOut(hostOut),
		.arrayReq(arrayReq), .arrayAddr(arrayAddr), .arrayValid(arrayValid), .arrayData(arrayData));
	fbr_array_model u_fbr_array_model (.clock(clock), .arst_n(arst_n), .arrayReq(arrayReq),
		.arrayAddr(arrayAddr), .slow(slow), .arrayValid(arrayValid), .arrayData(arrayData));
	initial begin
		forever #5 clock = ~clock;
	end
	task reportAndStop;
		if (badCount == 0 && nCompared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		repeat (2) begin
			k = 0;
			do begin
				@(posedge clock);
				k++;
			end while (hreadyout !== 1'h1 && k < 20);
			if (hreadyout !== 1'h1) begin
				badCount++;
				reportAndStop;
			end
			htrans <= 2'h0;
			hwdata <= d;
		end
		rd = hrdata;
	endtask
	task halfs(input int n);
		repeat (n) begin
			repeat (HALF) @(posedge clock);
			burstClk <= ~burstClk;
		end
	endtask
	task burst(input logic [2:0] len, input logic lin, input logic edg, input logic [15:0] st, input int n);
		int j, sz, d, lat, lowGap;
		logic [15:0] w;
		lat = 3;
		d = 0;
		lowGap = lat - 1 - (3 - int'(st[1:0]));
		sz = 4 << (len == `FBR_LEN_CONT ? 2 : len - 3'h1);
		ahb(1'h1, 32'h0, {16'h0, 2'h0, 3'(lat), 4'h0, edg, 2'h0, lin, len});
		burstClk <= ~edg;
		burstAddr <= st;
		burstEnable <= 1'h1;
		slow <= 1'($urandom_range(1));
		edgeSel = edg;
		waitCycles = 0;
		nWords += n;
		for (j = 0; j < n; j++) begin
			w = (len == `FBR_LEN_CONT || lin) ? st + 16'(j) : (st & ~16'(sz - 1)) | ((st + 16'(j)) & 16'(sz - 1));
			expQ.push_back(w ^ 16'ha5c3);
			// A linear burst from a misaligned start stalls once, when a later word crosses a row
			if ((len == `FBR_LEN_CONT || lin) && st[1:0] != 2'h0 && d == 0 && j < n - 1 && w[3:0] == 4'hf) begin
				d = (lowGap > 1) ? lowGap : 1;
			end
		end
		for (j = 0; expQ.size() > 0 && j < 400; j++) halfs(1);
		if (expQ.size() > 0) begin
			badCount++;
			reportAndStop;
		end
		// One burst period of wait for the start edge, one more per stalled edge
		`CHK("wait cycles", 2 * HALF * (1 + d), waitCycles)
		// Enable drops at once, else a finished burst restarts on the next active edge
		burstEnable <= 1'h0;
		halfs(12);
	endtask
	always @(posedge clock) begin
		if (arst_n) begin
			if (expQ.size() > 0 && burstEnable && hostOut.waitOut === 1'h1) waitCycles++;
			// Wait falling also marks a word, so a repeated data value is not missed
			if (burstEnable && hostOut.waitOut === 1'h0 && (hostOut.data !== prevData || prevWait === 1'h1)) begin
				if (expQ.size() == 0) `CHK("word count", 1'h0, 1'h1)
				else begin
					gotExp = expQ.pop_front();
					`CHK("word", gotExp, hostOut.data)
					`CHK("word edge", edgeSel, burstClk)
				end
			end
			prevData = hostOut.data;
			prevWait = hostOut.waitOut;
		end
	end
	initial begin
		void'($urandom(32'hea376e8e));
		repeat (3) @(posedge clock);
		arst_n <= 1'h1;
		@(posedge clock);
		ahb(1'h0, 32'h0, 32'h0);
		`CHK("cfg reset", `FBR_CFG_RESET, rd[15:0])
		ahb(1'h0, 32'h8, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		burst(3'h1, 1'h0, 1'h0, 16'h2, 4);
		burst(3'h1, 1'h1, 1'h1, 16'h3, 4);
		ahb(1'h0, 32'h0, 32'h0);
		`CHK("cfg", 16'h1849, rd[15:0])
		burst(3'h1, 1'h1, 1'h0, 16'h1f, 4);
		burst(3'h2, 1'h1, 1'h1, 16'h2a, 8);
		for (i = 0; i < 8; i++) begin
			burst(i % 4 == 3 ? 3'h7 : 3'(i % 4 + 1), 1'(i / 4), 1'(i), 16'($urandom_range(255)), 4 << (i % 4));
		end
		burst(3'h7, 1'h0, 1'h1, 16'hfffd, 3);
		ahb(1'h0, 32'h4, 32'h0);
		`CHK("status", {16'h0000, 16'(nWords)}, rd)
		reportAndStop;
	end
endmodule
